// File: src/spel_defs.vh
// Register map, field positions, reset values and timing counts
`ifndef SPEL_DEFS_VH
`define SPEL_DEFS_VH

// Register byte offsets
`define SPEL_OFS_CTRL   8'h00
`define SPEL_OFS_STAT   8'h04
`define SPEL_OFS_TXDATA 8'h08
`define SPEL_OFS_RXDATA 8'h0C
`define SPEL_OFS_BAUD   8'h10

// serial_control_reg fields
`define SPEL_C_TE    0
`define SPEL_C_RE    1
`define SPEL_C_TIE   2
`define SPEL_C_RIE   3
`define SPEL_C_TX_END_IRQ_ENABLE  4
`define SPEL_C_SYNC  5
`define SPEL_C_EXT   6
`define SPEL_C_PAREN 7

// serial_status_reg fields
`define SPEL_S_TDE  0
`define SPEL_S_RDF  1
`define SPEL_S_OVR  2
`define SPEL_S_FER  3
`define SPEL_S_PER  4
`define SPEL_S_TX_END_FLAG 5

// Reset values
`define SPEL_CTRL_RST 8'h00
`define SPEL_BAUD_RST 16'h0003
`define SPEL_DATA_RST 8'h00

// Base clock is sixteen ticks per bit
`define SPEL_PH_LAST  4'hF
`define SPEL_PH_MID   4'h7
`define SPEL_PH_ZERO  4'h0

// Bit counts
`define SPEL_SYNC_LEFT  4'h7
`define SPEL_ASYNC_LEFT 4'h9
`define SPEL_APAR_LEFT  4'hA
`define SPEL_RX_STOP    4'h9
`define SPEL_RX_PSTOP   4'hA
`define SPEL_RX_PAR     4'h9
`define SPEL_RX_START   4'h0
`define SPEL_CNT_ONE    4'h1

`endif

// File: src/spel_serial.v
// Serial port with status flags, four requests and error handling
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "spel_defs.vh"

module spel_serial (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        dma_tx_wr,
    input  wire [7:0]  dma_tx_data,
    input  wire        dma_rx_rd,
    output reg  [7:0]  dma_rx_data,
    input  wire        rxd,
    output reg         txd,
    input  wire        sck_in,
    output reg         sck_out,
    output reg         sck_oe,
    output reg         tx_end_request,
    output reg         rx_error_request,
    output reg         rx_full_request,
    output reg         tx_empty_request
);

////////////////////////////////////////////////////////////////////////
// Functions

// Even parity of a byte
function par8;
    input [7:0] d;
    begin
        par8 = ^d;
    end
endfunction

// Mapped register offset
function addr_ok;
    input [7:0] a;
    begin
        addr_ok = (a == `SPEL_OFS_CTRL) || (a == `SPEL_OFS_STAT) ||
                  (a == `SPEL_OFS_TXDATA) || (a == `SPEL_OFS_RXDATA) ||
                  (a == `SPEL_OFS_BAUD);
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Declarations

reg  [7:0]  ctrl_reg;
reg  [15:0] baud_reg;
reg  [15:0] base_cnt_reg;
reg         rxd_m_reg, rxd_s_reg;
reg         sck_m_reg, sck_s_reg, sck_d_reg;
reg  [3:0]  sph_reg;
reg  [7:0]  tx_data_reg;
reg         tx_empty_flag, tx_end_flag, tx_busy_reg;
reg  [9:0]  tx_frame_reg;
reg  [3:0]  tx_left_reg, tx_ph_reg;
reg         rx_busy_reg, rx_done_reg, fer_pend_reg, per_pend_reg;
reg  [3:0]  rx_div_reg, rx_cnt_reg;
reg  [7:0]  rx_shift_reg;
reg         rx_full_flag, overrun_flag, framing_err_flag, parity_err_flag;

wire tx_en   = ctrl_reg[`SPEL_C_TE];
wire rx_en   = ctrl_reg[`SPEL_C_RE];
wire sync_md = ctrl_reg[`SPEL_C_SYNC];
wire ext_clk = ctrl_reg[`SPEL_C_EXT];
wire par_en  = ctrl_reg[`SPEL_C_PAREN];
wire err_any = overrun_flag | framing_err_flag | parity_err_flag;

wire apb_setup = psel & ~penable;
wire apb_wr    = psel & penable & pready & pwrite;
wire wr_ctrl   = apb_wr & (paddr == `SPEL_OFS_CTRL);
wire wr_stat   = apb_wr & (paddr == `SPEL_OFS_STAT);
wire wr_txd    = apb_wr & (paddr == `SPEL_OFS_TXDATA);
wire wr_baud   = apb_wr & (paddr == `SPEL_OFS_BAUD);

// Base clock tick, sixteen per bit
wire tick = (base_cnt_reg == 16'h0000);

// Internal synchronous clock runs for transmit or receive-only
wire rx_only = rx_en & ~tx_en & ~err_any;
wire int_run = sync_md & ~ext_clk & (tx_busy_reg | rx_only);
wire int_rise = int_run & tick & (sph_reg == `SPEL_PH_MID);
wire int_fall = int_run & tick & (sph_reg == `SPEL_PH_LAST);
wire ext_rise = sck_s_reg & ~sck_d_reg;
wire ext_fall = ~sck_s_reg & sck_d_reg;
wire sync_step = ext_clk ? ext_fall : int_fall;
wire sync_samp = ext_clk ? ext_rise : int_rise;

// Transmit start and bit step
wire tx_start = tx_en & ~tx_empty_flag & ~(sync_md & err_any);
wire tx_step = sync_md ? sync_step
                       : (tick & (tx_ph_reg == `SPEL_PH_LAST));
wire tx_wr = wr_txd | dma_tx_wr;
wire [7:0] tx_wdata = dma_tx_wr ? dma_tx_data : pwdata[7:0];

// Frame to load: first bit driven at once, rest shifted later
reg        ld_first;
reg  [9:0] ld_rest;
reg  [3:0] ld_left;
always @* begin
    if (sync_md) begin
        ld_first = tx_data_reg[0];
        ld_rest  = {3'b111, tx_data_reg[7:1]};
        ld_left  = `SPEL_SYNC_LEFT;
    end else if (par_en) begin
        ld_first = 1'b0;
        ld_rest  = {1'b1, par8(tx_data_reg), tx_data_reg};
        ld_left  = `SPEL_APAR_LEFT;
    end else begin
        ld_first = 1'b0;
        ld_rest  = {2'b11, tx_data_reg};
        ld_left  = `SPEL_ASYNC_LEFT;
    end
end

// Receive sample strobes
wire a_samp = ~sync_md & rx_busy_reg & tick & (rx_div_reg == `SPEL_PH_MID);
wire a_start = ~sync_md & rx_en & ~rx_busy_reg & tick & ~rxd_s_reg;
wire s_samp = sync_md & rx_en & ~err_any & sync_samp;
wire [3:0] a_stop = par_en ? `SPEL_RX_PSTOP : `SPEL_RX_STOP;

////////////////////////////////////////////////////////////////////////
// APB slave, zero wait states

// Control and baud registers
always @(posedge mclk) begin
    if (sys_rst) begin
        ctrl_reg <= `SPEL_CTRL_RST;
        baud_reg <= `SPEL_BAUD_RST;
    end else begin
        if (wr_ctrl)
            ctrl_reg <= pwdata[7:0];
        if (wr_baud)
            baud_reg <= pwdata[15:0];
    end
end

// Read data and answer prepared in the setup cycle
always @(posedge mclk) begin
    if (sys_rst) begin
        prdata  <= 32'h00000000;
        pready  <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready  <= apb_setup;
        pslverr <= apb_setup & ~addr_ok(paddr);
        prdata  <= 32'h00000000;
        if (apb_setup & ~pwrite) begin
            case (paddr)
                `SPEL_OFS_CTRL:   prdata <= {24'h000000, ctrl_reg};
                `SPEL_OFS_STAT:   prdata <= {26'h0, tx_end_flag,
                    parity_err_flag, framing_err_flag, overrun_flag,
                    rx_full_flag, tx_empty_flag};
                `SPEL_OFS_TXDATA: prdata <= {24'h000000, tx_data_reg};
                `SPEL_OFS_RXDATA: prdata <= {24'h000000, dma_rx_data};
                `SPEL_OFS_BAUD:   prdata <= {16'h0000, baud_reg};
                default:          prdata <= 32'h00000000;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Synchronisers and clocks

// Two flip-flops on every pin input, third for edge detect
always @(posedge mclk) begin
    if (sys_rst) begin
        rxd_m_reg <= 1'b1;
        rxd_s_reg <= 1'b1;
        sck_m_reg <= 1'b1;
        sck_s_reg <= 1'b1;
        sck_d_reg <= 1'b1;
    end else begin
        rxd_m_reg <= rxd;
        rxd_s_reg <= rxd_m_reg;
        sck_m_reg <= sck_in;
        sck_s_reg <= sck_m_reg;
        sck_d_reg <= sck_s_reg;
    end
end

// Base clock divider, sixteen times bit rate
always @(posedge mclk) begin
    if (sys_rst)
        base_cnt_reg <= 16'h0000;
    else if (tick)
        base_cnt_reg <= baud_reg;
    else
        base_cnt_reg <= base_cnt_reg - 16'h0001;
end

// Internal serial clock, high when idle
always @(posedge mclk) begin
    if (sys_rst) begin
        sph_reg <= `SPEL_PH_ZERO;
        sck_out <= 1'b1;
        sck_oe  <= 1'b0;
    end else begin
        if (!int_run)
            sph_reg <= `SPEL_PH_ZERO;
        else if (tick)
            sph_reg <= sph_reg + 4'h1;
        sck_out <= ~int_run | sph_reg[3];
        sck_oe  <= sync_md & ~ext_clk;
    end
end

////////////////////////////////////////////////////////////////////////
// Transmitter

always @(posedge mclk) begin
    if (sys_rst) begin
        tx_data_reg   <= `SPEL_DATA_RST;
        tx_empty_flag <= 1'b1;
        tx_end_flag   <= 1'b1;
        tx_busy_reg   <= 1'b0;
        tx_frame_reg  <= 10'h3FF;
        tx_left_reg   <= 4'h0;
        tx_ph_reg     <= `SPEL_PH_ZERO;
        txd           <= 1'b1;
    end else if (!tx_en) begin
        // Disable stops any frame at once
        tx_busy_reg   <= 1'b0;
        tx_empty_flag <= 1'b1;
        tx_end_flag   <= 1'b1;
        tx_left_reg   <= 4'h0;
        tx_ph_reg     <= `SPEL_PH_ZERO;
        txd           <= 1'b1;
        if (tx_wr)
            tx_data_reg <= tx_wdata;
    end else begin
        if (tx_busy_reg & tick)
            tx_ph_reg <= tx_ph_reg + 4'h1;
        if ((!tx_busy_reg | (tx_step & (tx_left_reg == 4'h0)))
            & tx_start) begin
            // Load shift register and release data register
            txd           <= ld_first;
            tx_frame_reg  <= ld_rest;
            tx_left_reg   <= ld_left;
            tx_busy_reg   <= 1'b1;
            tx_ph_reg     <= `SPEL_PH_ZERO;
            tx_empty_flag <= 1'b1;
            tx_end_flag   <= 1'b0;
        end else if (tx_busy_reg & tx_step) begin
            if (tx_left_reg != 4'h0) begin
                txd          <= tx_frame_reg[0];
                tx_frame_reg <= {1'b1, tx_frame_reg[9:1]};
                tx_left_reg  <= tx_left_reg - 4'h1;
                if ((tx_left_reg == `SPEL_CNT_ONE) & tx_empty_flag)
                    tx_end_flag <= 1'b1;
            end else begin
                // Line holds the last level
                tx_busy_reg <= 1'b0;
                tx_end_flag <= 1'b1;
            end
        end
        // A write always lands, overwriting unsent data
        if (tx_wr) begin
            tx_data_reg   <= tx_wdata;
            tx_empty_flag <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Receiver

always @(posedge mclk) begin
    if (sys_rst) begin
        rx_busy_reg  <= 1'b0;
        rx_div_reg   <= `SPEL_PH_ZERO;
        rx_cnt_reg   <= 4'h0;
        rx_shift_reg <= `SPEL_DATA_RST;
        rx_done_reg  <= 1'b0;
        fer_pend_reg <= 1'b0;
        per_pend_reg <= 1'b0;
    end else begin
        rx_done_reg <= 1'b0;
        if (!rx_en) begin
            // Abort frame only, flags stay
            rx_busy_reg <= 1'b0;
            rx_cnt_reg  <= 4'h0;
        end else if (a_start) begin
            // Sync point on base clock, level low after idle
            rx_busy_reg  <= 1'b1;
            rx_div_reg   <= `SPEL_PH_ZERO;
            rx_cnt_reg   <= `SPEL_RX_START;
            per_pend_reg <= 1'b0;
            fer_pend_reg <= 1'b0;
        end else if (rx_busy_reg & ~sync_md) begin
            if (tick)
                rx_div_reg <= rx_div_reg + 4'h1;
            if (a_samp) begin
                // Eighth base pulse lands in mid bit
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
                if (rx_cnt_reg == `SPEL_RX_START) begin
                    if (rxd_s_reg)
                        rx_busy_reg <= 1'b0;
                end else if (rx_cnt_reg == a_stop) begin
                    // Break keeps giving framing errors
                    fer_pend_reg <= ~rxd_s_reg;
                    rx_busy_reg  <= 1'b0;
                    rx_done_reg  <= 1'b1;
                end else if (par_en & (rx_cnt_reg == `SPEL_RX_PAR)) begin
                    per_pend_reg <= rxd_s_reg ^ par8(rx_shift_reg);
                end else begin
                    rx_shift_reg <= {rxd_s_reg, rx_shift_reg[7:1]};
                end
            end
        end else if (s_samp) begin
            // Synchronous: eight rising edges per byte
            rx_shift_reg <= {rxd_s_reg, rx_shift_reg[7:1]};
            per_pend_reg <= 1'b0;
            fer_pend_reg <= 1'b0;
            if (rx_cnt_reg == `SPEL_SYNC_LEFT) begin
                rx_cnt_reg  <= 4'h0;
                rx_done_reg <= 1'b1;
            end else begin
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Receive flags and data hand-off

// Clears first, hardware sets after so a set wins
always @(posedge mclk) begin
    if (sys_rst) begin
        rx_full_flag     <= 1'b0;
        overrun_flag     <= 1'b0;
        framing_err_flag <= 1'b0;
        parity_err_flag  <= 1'b0;
        dma_rx_data      <= `SPEL_DATA_RST;
    end else begin
        if (wr_stat) begin
            if (!pwdata[`SPEL_S_RDF])
                rx_full_flag <= 1'b0;
            if (!pwdata[`SPEL_S_OVR])
                overrun_flag <= 1'b0;
            if (!pwdata[`SPEL_S_FER])
                framing_err_flag <= 1'b0;
            if (!pwdata[`SPEL_S_PER])
                parity_err_flag <= 1'b0;
        end
        if (dma_rx_rd)
            rx_full_flag <= 1'b0;
        if (rx_done_reg) begin
            if (fer_pend_reg)
                framing_err_flag <= 1'b1;
            if (per_pend_reg)
                parity_err_flag <= 1'b1;
            if (rx_full_flag) begin
                // Byte dropped, data register untouched
                overrun_flag <= 1'b1;
                rx_full_flag <= 1'b1;
            end else begin
                // Late rx disable: flag set, no copy
                if (rx_en)
                    dma_rx_data <= rx_shift_reg;
                if (!fer_pend_reg & !per_pend_reg)
                    rx_full_flag <= 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Request lines, flag AND enable

always @(posedge mclk) begin
    if (sys_rst) begin
        tx_end_request   <= 1'b0;
        rx_error_request <= 1'b0;
        rx_full_request  <= 1'b0;
        tx_empty_request <= 1'b0;
    end else begin
        tx_end_request   <= tx_end_flag & ctrl_reg[`SPEL_C_TX_END_IRQ_ENABLE];
        rx_error_request <= err_any & ctrl_reg[`SPEL_C_RIE];
        rx_full_request  <= rx_full_flag & ctrl_reg[`SPEL_C_RIE];
        tx_empty_request <= tx_empty_flag & ctrl_reg[`SPEL_C_TIE];
    end
end
// Four separate lines, ranked by the interrupt controller

endmodule // spel_serial

// File: tb/spel_serial_chk.sv
// Port assertions for the serial event and error block
`timescale 1ns/100ps
module spel_serial_chk (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        dma_rx_rd,
    input wire logic        txd,
    input wire logic        sck_out,
    input wire logic        sck_oe,
    input wire logic        tx_end_request,
    input wire logic        rx_error_request,
    input wire logic        rx_full_request,
    input wire logic        tx_empty_request
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    // Bus timing
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    a_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    a_slverr_zero: assert property (pslverr |-> pready && prdata == 0)
        else $error("error response malformed");
    ////////////////////////////////////////////////////////////////////////
    // Requests and lines
    a_reset_quiet: assert property (@(posedge mclk) disable iff (1'b0)
        sys_rst |=> !(tx_end_request || rx_error_request || rx_full_request
        || tx_empty_request) && txd && !sck_oe && !pready)
        else $error("outputs not quiet in reset");
    a_full_hold: assert property (rx_full_request && !psel && !dma_rx_rd
        && !$past(psel) && !$past(dma_rx_rd) |=> rx_full_request)
        else $error("full request dropped without clear");
    a_err_hold: assert property (rx_error_request && !psel
        && !$past(psel) |=> rx_error_request)
        else $error("error request dropped without clear");
    a_dma_rxclr: assert property (dma_rx_rd && rx_full_request
        |-> ##2 !rx_full_request)
        else $error("dma read left full request");
    a_sck_idle: assert property (!sck_oe |-> sck_out)
        else $error("clock output low while not driven");
endmodule // spel_serial_chk

// File: tb/spel_peer.sv
// Remote serial peer: sends frames, clocks bytes in, catches frames
`timescale 1ns/100ps
module spel_peer (
    output logic      rxd,
    input  wire logic txd,
    output logic      sck_in
);
    localparam int BIT_NS = 640; // Divisor 3: 16 ticks of 4 clocks
    logic [7:0] got_q[$];
    logic [7:0] cap;
    bit         sync_mode = 1'b0;
    // Mark level on data, clock parked high between frames
    initial begin
        rxd = 1'b1;
        sck_in = 1'b1;
    end
    // Async frame LSB first; bad_stop drives stop low
    task automatic send(input logic [7:0] b, input bit bad_stop);
        #2; // Line moves off the clock edge
        for (int i = 0; i < 10; i++) begin
            rxd = (i == 0) ? 1'b0 : (i == 9) ? !bad_stop : b[i-1];
            #(BIT_NS);
        end
        rxd = 1'b1;
    endtask
    // Eight 160 ns clocks, data changed while clock low
    task automatic clock_in(input logic [7:0] b);
        #2; // Clock moves off the system clock edge
        for (int i = 0; i < 8; i++) begin
            sck_in = 1'b0;
            rxd = b[i];
            #80;
            sck_in = 1'b1;
            #80;
        end
        rxd = !b[7]; // Released line shows no stale bit
    endtask
    // Catch async frames, sampled mid-bit
    always begin
        @(negedge txd);
        if (!sync_mode) begin
            #(BIT_NS / 2);
            for (int i = 0; i < 8; i++) begin
                #(BIT_NS);
                cap[i] = txd;
            end
            got_q.push_back(cap);
        end
    end
endmodule // spel_peer

// File: tb/tb_spel_serial.sv
// Self-checking bench for the serial event and error block
`timescale 1ns/100ps
module tb_spel_serial;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        dma_tx_wr = 1'b0;
    logic        dma_rx_rd = 1'b0;
    logic [7:0]  dma_tx_data = 8'h00;
    logic [31:0] prdata, rd;
    logic [7:0]  dma_rx_data, b, v;
    logic        pready, pslverr, err, rxd, txd, sck_in, sck_out, sck_oe;
    logic        tx_end_request, rx_error_request;
    logic        rx_full_request, tx_empty_request;
    logic [7:0]  exp_q[$];
    int          bad_count = 0;
    int          checked = 0;
    int          seed = 2;
    int          n;
    spel_serial uut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .dma_tx_wr, .dma_tx_data,
        .dma_rx_rd, .dma_rx_data, .rxd, .txd, .sck_in, .sck_out, .sck_oe,
        .tx_end_request, .rx_error_request, .rx_full_request,
        .tx_empty_request);
    spel_peer peer (.rxd, .txd, .sck_in);
    always #5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////
    // Compare, bus cycle, bounded waits
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic await(input int s);
        for (n = 0; n < 3000; n++) begin
            @(posedge mclk);
            if (s == 0 && rx_full_request === 1'b1) break;
            if (s == 1 && rx_error_request === 1'b1) break;
            if (s == 2 && peer.got_q.size() >= exp_q.size()) break;
        end
        chk(n < 3000, 1'b1); // Wait ran out
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (40000) @(posedge mclk);
        bad_count++;
        complete_run;
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h21);
        rdc(8'h10, 32'h3);
        rdc(8'h14, 32'h0);
        chk(err, 1'b1);
        $display("reset test done");
        // Async send; third write overwrites a pending byte
        apb(1'b1, 8'h00, 32'h15);
        @(posedge mclk);
        chk({tx_end_request, tx_empty_request}, 2'b11);
        b = $random(seed);
        apb(1'b1, 8'h08, b);
        apb(1'b1, 8'h08, 32'h5A);
        apb(1'b1, 8'h08, 32'h77);
        exp_q = '{b, 8'h77};
        await(2);
        foreach (exp_q[i]) chk(peer.got_q[i], exp_q[i]);
        repeat (700) @(posedge mclk);
        chk({tx_end_request, tx_empty_request, txd}, 3'b111);
        $display("tx test done");
        // Dma write of the data register
        b = $random(seed);
        dma_tx_wr <= 1'b1;
        dma_tx_data <= b;
        @(posedge mclk);
        dma_tx_wr <= 1'b0;
        for (n = 0; n < 4 && tx_empty_request !== 1'b0; n++) @(posedge mclk);
        chk(tx_empty_request, 1'b0);
        exp_q.push_back(b);
        await(2);
        chk(peer.got_q[2], b);
        repeat (700) @(posedge mclk);
        $display("dma tx test done");
        // Transmitter disabled in mid-frame
        apb(1'b1, 8'h08, 32'h3C);
        for (n = 0; n < 99 && txd !== 1'b0; n++) @(posedge mclk);
        chk(txd, 1'b0);
        repeat (100) @(posedge mclk);
        apb(1'b1, 8'h00, 32'h0);
        @(posedge mclk);
        chk(txd, 1'b1);
        rdc(8'h04, 32'h21);
        repeat (800) @(posedge mclk);
        peer.got_q.delete();
        $display("tx abort test done");
        // Async receive and dma read
        apb(1'b1, 8'h00, 32'h0A);
        b = $random(seed);
        peer.send(b, 1'b0);
        await(0);
        chk(rx_full_request, 1'b1);
        rdc(8'h0C, b);
        chk(dma_rx_data, b);
        dma_rx_rd <= 1'b1;
        @(posedge mclk);
        dma_rx_rd <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(rx_full_request, 1'b0);
        // Break then framing error: flags set, byte copied
        for (int k = 0; k < 2; k++) begin
            v = k ? 8'($random(seed)) : 8'h00;
            peer.send(v, 1'b1);
            await(1);
            rdc(8'h04, 32'h29);
            rdc(8'h0C, v);
            apb(1'b1, 8'h04, 32'h0);
        end
        // Even parity on: parity bit 1 after even data is an error
        apb(1'b1, 8'h00, 32'h8A);
        peer.send(8'h33, 1'b0);
        await(1);
        rdc(8'h04, 32'h31);
        rdc(8'h0C, 32'h33);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h00, 32'h0A);
        $display("rx error test done");
        // Overrun keeps old byte; disable keeps flags
        peer.send(b, 1'b0);
        await(0);
        v = $random(seed);
        peer.send(v, 1'b0);
        await(1);
        rdc(8'h04, 32'h27);
        rdc(8'h0C, b);
        apb(1'b1, 8'h00, 32'h08);
        rdc(8'h04, 32'h27);
        apb(1'b1, 8'h00, 32'h0);
        @(posedge mclk);
        chk({rx_error_request, rx_full_request}, 2'b00);
        apb(1'b1, 8'h04, 32'h0);
        $display("overrun test done");
        // External clocked mode: error flag blocks transmit
        peer.sync_mode = 1'b1;
        apb(1'b1, 8'h00, 32'h62);
        peer.clock_in(b);
        repeat (10) @(posedge mclk);
        rdc(8'h04, 32'h23);
        rdc(8'h0C, b);
        peer.clock_in(v);
        repeat (10) @(posedge mclk);
        rdc(8'h04, 32'h27);
        apb(1'b1, 8'h00, 32'h63);
        apb(1'b1, 8'h08, 32'h96);
        repeat (20) @(posedge mclk);
        rdc(8'h04, 32'h26);
        apb(1'b1, 8'h04, 32'h0);
        repeat (4) @(posedge mclk);
        rdc(8'h04, 32'h01);
        $display("clocked test done");
        // Internal clock: eight clocks out, data caught on rising edges
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h21);
        b = 8'($random(seed));
        apb(1'b1, 8'h08, b);
        for (int k = 0; k < 8; k++) begin
            @(posedge sck_out);
            v[k] = txd;
        end
        chk(v, b);
        chk(sck_oe, 1'b1);
        repeat (100) @(posedge mclk);
        chk({sck_out, txd}, {1'b1, b[7]});
        $display("internal clock test done");
        complete_run;
    end
endmodule // tb_spel_serial
bind spel_serial spel_serial_chk chk (.mclk, .sys_rst, .psel, .penable,
    .prdata, .pready, .pslverr, .dma_rx_rd, .txd, .sck_out, .sck_oe,
    .tx_end_request, .rx_error_request, .rx_full_request,
    .tx_empty_request);
